// File: emff_pkg.sv
package emff_pkg;

    // ************************************************************
    // Register map and field positions
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_TX_CTL = 8'h00;
    localparam logic [7:0] OFF_RX_CTL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_TX_DATA = 8'h10;
    localparam logic [7:0] OFF_TX_GO = 8'h14;
    localparam logic [7:0] OFF_RX_DATA = 8'h18;
    localparam logic [7:0] OFF_RX_LEVEL = 8'h1C;
    localparam logic [7:0] OFF_RX_INFO = 8'h20;
    localparam logic [7:0] OFF_TX_LEVEL = 8'h24;
    localparam int TXC_PAD = 0;
    localparam int TXC_CRC = 1;
    localparam int RXC_EN = 0;
    localparam int RXC_REJ = 1;
    localparam int IS_TXDONE = 0;
    localparam int IS_RXOK = 1;
    localparam int IS_RXERR = 2;
    localparam int IS_FOV = 3;
    localparam logic [1:0] TX_CTL_RST = 2'h3;
    localparam logic [1:0] RX_CTL_RST = 2'h2;

    // ************************************************************
    // Buffers, framing constants and check sequence
    // ************************************************************
    localparam logic [11:0] BUF_DEPTH = 12'h800;
    localparam logic [11:0] PRE_OCTETS = 12'h007;
    localparam logic [11:0] PRE_LAST_NIB = 12'h00F;
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hD5;
    localparam logic [11:0] HDR_OCTETS = 12'h00E;
    localparam logic [11:0] MIN_PAYLOAD = 12'h02E;
    localparam logic [11:0] MIN_FRAME = HDR_OCTETS + MIN_PAYLOAD;
    localparam logic [15:0] LT_HI_IDX = 16'h000C;
    localparam logic [15:0] LT_LO_IDX = 16'h000D;
    localparam logic [15:0] MAX_LENGTH = 16'h05DC;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
    localparam logic [11:0] FCS_LAST_NIB = 12'h007;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_PRE = 5'h02,
        TX_DATA = 5'h04,
        TX_PAD = 5'h08,
        TX_FCS = 5'h10
    } emff_tx_st_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_PRE = 4'h2,
        RX_DATA = 4'h4,
        RX_DROP = 4'h8
    } emff_rx_st_t;

endpackage

// File: emff_crc_nibble.sv
// ************************************************************
// Reflected CRC-32 step, four bits per call
// ************************************************************
module emff_crc_nibble (
    input wire logic [31:0] crc_in,
    input wire logic [3:0] nib,
    output logic [31:0] crc_out
);

    // Bits enter low first, matching the wire order of each nibble.
    always_comb begin
        crc_out = crc_in;
        for (int i = 0; i < 4; i++) begin
            if (crc_out[0] ^ nib[i]) begin
                crc_out = (crc_out >> 1) ^ emff_pkg::CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end

endmodule

// File: emff_mac.sv
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
module emff_mac (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    output logic irq,
    output logic mii_tx_en,
    output logic [3:0] mii_txd,
    input wire logic mii_rx_dv,
    input wire logic [3:0] mii_rxd
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [1:0] tx_ctl, next_tx_ctl, rx_ctl, next_rx_ctl;
    logic [3:0] status, next_status, mask, next_mask;
    logic [31:0] next_rd_data;
    logic [7:0] tx_mem [2048];
    logic [7:0] rx_mem [2048];
    emff_pkg::emff_tx_st_t tx_st, next_tx_st;
    logic [11:0] tx_cnt, next_tx_cnt, tx_len, next_tx_len, tx_wr, next_tx_wr;
    logic [31:0] tx_crc, next_tx_crc, fcs_sh, next_fcs_sh, tx_crc_step;
    logic [3:0] next_txd, tx_nib;
    logic next_tx_en, tx_hi, next_tx_hi, tx_push, tx_go, tx_done_evt;
    logic [7:0] tx_byte, pre_byte;
    emff_pkg::emff_rx_st_t rx_st, next_rx_st;
    logic [11:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr, rx_tmp, next_rx_tmp, rx_used;
    logic [31:0] rx_crc, next_rx_crc, rx_crc_step;
    logic [15:0] rx_cnt, next_rx_cnt, rx_lt, next_rx_lt;
    logic [3:0] rx_lo, next_rx_lo;
    logic [7:0] rx_byte;
    logic rx_hi, next_rx_hi, rx_group, next_rx_group, rx_is_len, next_rx_is_len;
    logic rx_push, rx_pop, rx_ok_evt, rx_err_evt, rx_fov_evt;

    emff_crc_nibble u_tx_crc (
        .crc_in(tx_crc),
        .nib(tx_nib),
        .crc_out(tx_crc_step)
    );

    emff_crc_nibble u_rx_crc (
        .crc_in(rx_crc),
        .nib(mii_rxd),
        .crc_out(rx_crc_step)
    );

    // ************************************************************
    // Register port
    // ************************************************************
    // Status bits are sticky; a new event in the clearing cycle survives.
    always_comb begin
        logic [3:0] set_bits;
        logic [3:0] clr_bits;
        set_bits = 4'h0;
        clr_bits = 4'h0;
        next_tx_ctl = tx_ctl;
        next_rx_ctl = rx_ctl;
        next_mask = mask;
        next_rd_data = 32'h0;
        set_bits[emff_pkg::IS_TXDONE] = tx_done_evt;
        set_bits[emff_pkg::IS_RXOK] = rx_ok_evt;
        set_bits[emff_pkg::IS_RXERR] = rx_err_evt;
        set_bits[emff_pkg::IS_FOV] = rx_fov_evt;
        if (wr_en) begin
            unique case (addr)
                emff_pkg::OFF_TX_CTL: next_tx_ctl = wr_data[1:0];
                emff_pkg::OFF_RX_CTL: next_rx_ctl = wr_data[1:0];
                emff_pkg::OFF_STATUS: clr_bits = wr_data[3:0];
                emff_pkg::OFF_MASK: next_mask = wr_data[3:0];
                default: ;
            endcase
        end
        next_status = (status & ~clr_bits) | set_bits;
        if (rd_en) begin
            unique case (addr)
                emff_pkg::OFF_TX_CTL: next_rd_data = {30'h0, tx_ctl};
                emff_pkg::OFF_RX_CTL: next_rd_data = {30'h0, rx_ctl};
                emff_pkg::OFF_STATUS: next_rd_data = {28'h0, status};
                emff_pkg::OFF_MASK: next_rd_data = {28'h0, mask};
                emff_pkg::OFF_RX_DATA: next_rd_data = {24'h0, rx_mem[rd_ptr[10:0]]};
                emff_pkg::OFF_RX_LEVEL: next_rd_data = {20'h0, wr_ptr - rd_ptr};
                emff_pkg::OFF_RX_INFO: next_rd_data = {14'h0, rx_is_len, rx_group, rx_lt};
                emff_pkg::OFF_TX_LEVEL: next_rd_data = {19'h0, tx_st != emff_pkg::TX_IDLE, tx_wr};
                default: next_rd_data = 32'h0;
            endcase
        end
    end

    // Register file state; irq is a level of any unmasked status bit.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ctl <= emff_pkg::TX_CTL_RST;
            rx_ctl <= emff_pkg::RX_CTL_RST;
            status <= 4'h0;
            mask <= 4'h0;
            rd_data <= 32'h0;
        end else begin
            tx_ctl <= next_tx_ctl;
            rx_ctl <= next_rx_ctl;
            status <= next_status;
            mask <= next_mask;
            rd_data <= next_rd_data;
        end
    end

    assign irq = |(status & mask);

    // ************************************************************
    // Transmit framer
    // ************************************************************
    assign tx_push = wr_en && addr == emff_pkg::OFF_TX_DATA && tx_st == emff_pkg::TX_IDLE &&
                     tx_wr != emff_pkg::BUF_DEPTH;
    assign tx_go = wr_en && addr == emff_pkg::OFF_TX_GO && tx_st == emff_pkg::TX_IDLE && tx_wr != 12'h0;
    assign tx_byte = tx_mem[tx_cnt[10:0]];
    assign pre_byte = (tx_cnt < {emff_pkg::PRE_OCTETS[10:0], 1'b0}) ? emff_pkg::PRE_BYTE : emff_pkg::SFD_BYTE;
    // Payload octets go out raw, low nibble first; pad octets are zero.
    assign tx_nib = (tx_st == emff_pkg::TX_DATA) ? (tx_hi ? tx_byte[7:4] : tx_byte[3:0]) : 4'h0;

    // Frame sequencing: preamble, delimiter, buffer octets, pad, check.
    always_comb begin
        next_tx_st = tx_st;
        next_tx_cnt = tx_cnt;
        next_tx_len = tx_len;
        next_tx_hi = tx_hi;
        next_tx_crc = tx_crc;
        next_fcs_sh = fcs_sh;
        next_tx_wr = tx_push ? tx_wr + 12'h1 : tx_wr;
        next_txd = 4'h0;
        next_tx_en = 1'b0;
        tx_done_evt = 1'b0;
        unique case (tx_st)
            emff_pkg::TX_IDLE: begin
                if (tx_go) begin
                    next_tx_len = tx_wr;
                    next_tx_cnt = 12'h0;
                    next_tx_st = emff_pkg::TX_PRE;
                end
            end
            emff_pkg::TX_PRE: begin
                next_tx_en = 1'b1;
                next_txd = tx_cnt[0] ? pre_byte[7:4] : pre_byte[3:0];
                next_tx_cnt = tx_cnt + 12'h1;
                if (tx_cnt == emff_pkg::PRE_LAST_NIB) begin
                    next_tx_cnt = 12'h0;
                    next_tx_hi = 1'b0;
                    next_tx_crc = emff_pkg::CRC_INIT;
                    next_tx_st = emff_pkg::TX_DATA;
                end
            end
            emff_pkg::TX_DATA, emff_pkg::TX_PAD: begin
                next_tx_en = 1'b1;
                next_txd = tx_nib;
                next_tx_crc = tx_crc_step;
                next_tx_hi = !tx_hi;
                if (tx_hi) begin
                    next_tx_cnt = tx_cnt + 12'h1;
                    // Long frames run to the buffer end; no length limit applies.
                    if (tx_st == emff_pkg::TX_DATA && next_tx_cnt == tx_len &&
                        tx_ctl[emff_pkg::TXC_PAD] && tx_len < emff_pkg::MIN_FRAME) begin
                        next_tx_st = emff_pkg::TX_PAD;
                    end else if ((tx_st == emff_pkg::TX_DATA && next_tx_cnt == tx_len) ||
                                 (tx_st == emff_pkg::TX_PAD && next_tx_cnt == emff_pkg::MIN_FRAME)) begin
                        next_tx_cnt = 12'h0;
                        next_fcs_sh = ~tx_crc_step;
                        next_tx_st = tx_ctl[emff_pkg::TXC_CRC] ? emff_pkg::TX_FCS : emff_pkg::TX_IDLE;
                    end
                end
            end
            emff_pkg::TX_FCS: begin
                next_tx_en = 1'b1;
                next_txd = fcs_sh[3:0];
                next_fcs_sh = {4'h0, fcs_sh[31:4]};
                next_tx_cnt = tx_cnt + 12'h1;
                if (tx_cnt == emff_pkg::FCS_LAST_NIB) begin
                    next_tx_st = emff_pkg::TX_IDLE;
                end
            end
        endcase
        // Leaving the frame frees the buffer for the next one.
        if (tx_st != emff_pkg::TX_IDLE && tx_st != emff_pkg::TX_PRE && next_tx_st == emff_pkg::TX_IDLE) begin
            tx_done_evt = 1'b1;
            next_tx_wr = 12'h0;
        end
    end

    // Transmit state; the MII outputs are registered to keep them glitch free.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_st <= emff_pkg::TX_IDLE;
            tx_cnt <= 12'h0;
            tx_len <= 12'h0;
            tx_wr <= 12'h0;
            tx_hi <= 1'b0;
            tx_crc <= emff_pkg::CRC_INIT;
            fcs_sh <= 32'h0;
            mii_txd <= 4'h0;
            mii_tx_en <= 1'b0;
        end else begin
            tx_st <= next_tx_st;
            tx_cnt <= next_tx_cnt;
            tx_len <= next_tx_len;
            tx_wr <= next_tx_wr;
            tx_hi <= next_tx_hi;
            tx_crc <= next_tx_crc;
            fcs_sh <= next_fcs_sh;
            mii_txd <= next_txd;
            mii_tx_en <= next_tx_en;
        end
    end

    // Buffer storage carries no reset; only pointers define its contents.
    always_ff @(posedge mclk) begin
        if (tx_push) begin
            tx_mem[tx_wr[10:0]] <= wr_data[7:0];
        end
        if (rx_push) begin
            rx_mem[rx_tmp[10:0]] <= rx_byte;
        end
    end

    // ************************************************************
    // Receive checker
    // ************************************************************
    assign rx_byte = {mii_rxd, rx_lo};
    assign rx_used = rx_tmp - rd_ptr;
    assign rx_pop = rd_en && addr == emff_pkg::OFF_RX_DATA && rd_ptr != wr_ptr;

    // Octets are written ahead of the commit pointer; a failed frame rewinds.
    always_comb begin
        next_rx_st = rx_st;
        next_rx_hi = rx_hi;
        next_rx_lo = rx_lo;
        next_rx_crc = rx_crc;
        next_rx_tmp = rx_tmp;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rx_pop ? rd_ptr + 12'h1 : rd_ptr;
        next_rx_cnt = rx_cnt;
        next_rx_lt = rx_lt;
        next_rx_group = rx_group;
        next_rx_is_len = rx_is_len;
        rx_push = 1'b0;
        rx_ok_evt = 1'b0;
        rx_err_evt = 1'b0;
        rx_fov_evt = 1'b0;
        unique case (rx_st)
            emff_pkg::RX_IDLE: begin
                if (mii_rx_dv && rx_ctl[emff_pkg::RXC_EN]) begin
                    next_rx_st = emff_pkg::RX_PRE;
                end
            end
            emff_pkg::RX_PRE: begin
                if (!mii_rx_dv) begin
                    next_rx_st = emff_pkg::RX_IDLE;
                end else if (mii_rxd == emff_pkg::SFD_BYTE[7:4]) begin
                    next_rx_st = emff_pkg::RX_DATA;
                    next_rx_hi = 1'b0;
                    next_rx_crc = emff_pkg::CRC_INIT;
                    next_rx_tmp = wr_ptr;
                    next_rx_cnt = 16'h0;
                end
            end
            emff_pkg::RX_DATA: begin
                if (!mii_rx_dv) begin
                    next_rx_st = emff_pkg::RX_IDLE;
                    if (rx_crc == emff_pkg::CRC_RESIDUE || !rx_ctl[emff_pkg::RXC_REJ]) begin
                        next_wr_ptr = rx_tmp;
                        rx_ok_evt = 1'b1;
                    end else begin
                        rx_err_evt = 1'b1;
                    end
                end else begin
                    next_rx_crc = rx_crc_step;
                    next_rx_hi = !rx_hi;
                    next_rx_lo = mii_rxd;
                    if (rx_hi && rx_used == emff_pkg::BUF_DEPTH) begin
                        rx_fov_evt = 1'b1;
                        next_rx_st = emff_pkg::RX_DROP;
                    end else if (rx_hi) begin
                        rx_push = 1'b1;
                        next_rx_tmp = rx_tmp + 12'h1;
                        next_rx_cnt = rx_cnt + 16'h1;
                        if (rx_cnt == 16'h0) begin
                            next_rx_group = rx_byte[0];
                        end
                        if (rx_cnt == emff_pkg::LT_HI_IDX) begin
                            next_rx_lt = {rx_byte, 8'h00};
                        end
                        if (rx_cnt == emff_pkg::LT_LO_IDX) begin
                            next_rx_lt = {rx_lt[15:8], rx_byte};
                            next_rx_is_len = {rx_lt[15:8], rx_byte} <= emff_pkg::MAX_LENGTH;
                        end
                    end
                end
            end
            emff_pkg::RX_DROP: begin
                if (!mii_rx_dv) begin
                    next_rx_st = emff_pkg::RX_IDLE;
                end
            end
        endcase
    end

    // Receive state and buffer pointers.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st <= emff_pkg::RX_IDLE;
            rx_hi <= 1'b0;
            rx_lo <= 4'h0;
            rx_crc <= emff_pkg::CRC_INIT;
            rx_tmp <= 12'h0;
            wr_ptr <= 12'h0;
            rd_ptr <= 12'h0;
            rx_cnt <= 16'h0;
            rx_lt <= 16'h0;
            rx_group <= 1'b0;
            rx_is_len <= 1'b0;
        end else begin
            rx_st <= next_rx_st;
            rx_hi <= next_rx_hi;
            rx_lo <= next_rx_lo;
            rx_crc <= next_rx_crc;
            rx_tmp <= next_rx_tmp;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            rx_cnt <= next_rx_cnt;
            rx_lt <= next_rx_lt;
            rx_group <= next_rx_group;
            rx_is_len <= next_rx_is_len;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_preamble_sfd: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(mii_tx_en) |-> (mii_txd == 4'h5)[*8] ##1 (mii_txd == 4'h5)[*7] ##1 (mii_txd == 4'hD))
        else $error("Preamble or delimiter malformed.");
    a_pad_only_enabled: assert property (@(posedge mclk) disable iff (!arst_n)
        (tx_st == emff_pkg::TX_PAD) |->
        tx_ctl[emff_pkg::TXC_PAD] && ($past(tx_st) == emff_pkg::TX_DATA || mii_txd == 4'h0))
        else $error("Padding sent while disabled.");
    a_fcs_eight_nibbles: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(tx_st == emff_pkg::TX_FCS) |->
        (tx_st == emff_pkg::TX_FCS)[*8] ##1 (tx_st == emff_pkg::TX_IDLE && mii_tx_en))
        else $error("Check sequence length wrong.");
    a_fcs_only_enabled: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(tx_st == emff_pkg::TX_FCS) |-> $past(tx_ctl[emff_pkg::TXC_CRC]))
        else $error("Check sequence sent while disabled.");
    a_group_capture: assert property (@(posedge mclk) disable iff (!arst_n)
        (rx_push && rx_cnt == 16'h0) |=> rx_group == $past(rx_lo[0]))
        else $error("Group bit not captured.");
    a_len_type: assert property (@(posedge mclk) disable iff (!arst_n)
        (rx_push && rx_cnt == emff_pkg::LT_LO_IDX) |=> rx_is_len == (rx_lt <= 16'h05DC))
        else $error("Length/type decision wrong.");
    a_bad_dropped: assert property (@(posedge mclk) disable iff (!arst_n)
        (rx_st == emff_pkg::RX_DATA && !mii_rx_dv && rx_crc != emff_pkg::CRC_RESIDUE && rx_ctl[emff_pkg::RXC_REJ])
        |=> wr_ptr == $past(wr_ptr) && status[emff_pkg::IS_RXERR])
        else $error("Bad frame was stored or not flagged.");
    a_overrun_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        (rx_st == emff_pkg::RX_DATA && mii_rx_dv && rx_hi && rx_used == 12'h800)
        |=> status[emff_pkg::IS_FOV] && rx_st == emff_pkg::RX_DROP)
        else $error("Overrun not flagged.");
    c_tx_padded: cover property (@(posedge mclk) disable iff (!arst_n) $rose(tx_st == emff_pkg::TX_PAD));
    c_rx_good: cover property (@(posedge mclk) disable iff (!arst_n) rx_ok_evt);
    c_rx_bad: cover property (@(posedge mclk) disable iff (!arst_n) rx_err_evt);
    c_rx_overrun: cover property (@(posedge mclk) disable iff (!arst_n) rx_fov_evt);

endmodule

// File: emff_phy_model.sv
// ************************************************************
// Transceiver side of the internal media interface
// ************************************************************
module emff_phy_model (
    input wire logic mclk,
    input wire logic tx_en,
    input wire logic [3:0] txd,
    output logic rx_dv,
    output logic [3:0] rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] tx_nib[$];
    // Record every nibble shown while the enable is high, so framing is judged later.
    always @(posedge mclk) begin
        if (tx_en) begin
            tx_nib.push_back(txd);
        end
    end
    // The line starts idle with a value that no preamble or delimiter nibble would carry.
    initial begin
        rx_dv = 1'b0;
        rxd = 4'hA;
    end
    // Sends preamble, delimiter and octets low nibble first, then leaves the inverse on the idle line.
    task automatic send(input logic [7:0] q[$]);
        for (int i = 0; i < 16 + 2 * q.size(); i++) begin
            @(posedge mclk);
            rx_dv <= 1'b1;
            rxd <= (i < 15) ? 4'h5 : (i == 15) ? 4'hD : (i[0] ? q[i/2-8][7:4] : q[i/2-8][3:0]);
        end
        @(posedge mclk);
        rx_dv <= 1'b0;
        rxd <= ~rxd;
    endtask
endmodule

// File: emff_mac_tb.sv
module emff_mac_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rd_data, v;
    logic irq, mii_tx_en, mii_rx_dv;
    logic [3:0] mii_txd, mii_rxd;
    logic [7:0] f[$], e[$];
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // ************************************************************
    // Clock, design and transceiver model
    // ************************************************************
    always #25 mclk = ~mclk;
    emff_mac dut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .irq(irq), .mii_tx_en(mii_tx_en), .mii_txd(mii_txd), .mii_rx_dv(mii_rx_dv),
        .mii_rxd(mii_rxd));
    emff_phy_model phy (.mclk(mclk), .tx_en(mii_tx_en), .txd(mii_txd), .rx_dv(mii_rx_dv), .rxd(mii_rxd));
    // A hang is cut short well after the longest frame would have ended.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    // Each access leaves one idle edge after it, so a strobe is never set and cleared in one step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rd_data;
        @(posedge mclk);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] x);
        rd(a, v);
        chk(n, x, v);
    endtask
    // Bitwise reference of the check sequence; slow, but independent of the nibble engine.
    function automatic logic [31:0] fcs(input logic [7:0] q[$]);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        foreach (q[i]) begin
            for (int b = 0; b < 8; b++) begin
                c = (c >> 1) ^ ((c[0] ^ q[i][b]) ? emff_pkg::CRC_POLY : 32'h0);
            end
        end
        return ~c;
    endfunction
    task automatic add_fcs(ref logic [7:0] q[$]);
        logic [31:0] c;
        c = fcs(q);
        for (int k = 0; k < 4; k++) begin
            q.push_back(c[8*k+:8]);
        end
    endtask
    // Loads octets, starts the frame and compares every nibble seen on the wire.
    task automatic tx_frame(input logic [7:0] q[$], input logic [7:0] x[$]);
        phy.tx_nib.delete();
        foreach (q[i]) begin
            wr(emff_pkg::OFF_TX_DATA, {24'h0, q[i]});
        end
        rc("tx level", emff_pkg::OFF_TX_LEVEL, q.size());
        wr(emff_pkg::OFF_TX_GO, 32'h1);
        v = 32'h0;
        for (int k = 0; k < 400 && v[0] !== 1'b1; k++) begin
            rd(emff_pkg::OFF_STATUS, v);
        end
        repeat (4) @(posedge mclk);
        chk("tx nibbles", 16 + 2 * x.size(), phy.tx_nib.size());
        for (int i = 0; i < 16 + 2 * x.size(); i++) begin
            chk("txd", (i < 15) ? 4'h5 : (i == 15) ? 4'hD : i[0] ? x[i/2-8][7:4] : x[i/2-8][3:0],
                phy.tx_nib[i]);
        end
        wr(emff_pkg::OFF_STATUS, 32'h1);
        $display("transmit test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rc("tx ctl", emff_pkg::OFF_TX_CTL, 32'h3);
        rc("rx ctl", emff_pkg::OFF_RX_CTL, 32'h2);
        rc("unmapped", 8'h40, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            f.push_back(i < 12 ? 8'(i + 1) : i == 12 ? 8'h00 : i == 13 ? 8'h02 :
                        i == 14 ? 8'h55 : 8'hD5);
        end
        e = f;
        while (e.size() < 60) begin
            e.push_back(8'h00);
        end
        add_fcs(e);
        tx_frame(f, e);
        wr(emff_pkg::OFF_TX_CTL, 32'h0);
        e = f;
        add_fcs(e);
        tx_frame(e, e);
        wr(emff_pkg::OFF_RX_CTL, 32'h3);
        wr(emff_pkg::OFF_MASK, 32'h6);
        phy.send(e);
        repeat (4) @(posedge mclk);
        rc("status", emff_pkg::OFF_STATUS, 32'h2);
        rc("rx info", emff_pkg::OFF_RX_INFO, 32'h30002);
        rc("rx level", emff_pkg::OFF_RX_LEVEL, 32'h14);
        for (int i = 0; i < 20; i++) begin
            rd(emff_pkg::OFF_RX_DATA, v);
            chk("rx byte", e[i], v[7:0]);
        end
        // The tasks return on an edge; irq is settled from the previous edge's registers.
        chk("irq set", 32'h1, {31'h0, irq});
        wr(emff_pkg::OFF_STATUS, 32'h2);
        chk("irq clear", 32'h0, {31'h0, irq});
        e[19] = ~e[19];
        phy.send(e);
        repeat (4) @(posedge mclk);
        rc("status", emff_pkg::OFF_STATUS, 32'h4);
        rc("rx level", emff_pkg::OFF_RX_LEVEL, 32'h0);
        wr(emff_pkg::OFF_STATUS, 32'h4);
        f[0] = 8'h02;
        f[12] = 8'h05;
        f[13] = 8'hDD;
        e = f;
        add_fcs(e);
        phy.send(e);
        repeat (4) @(posedge mclk);
        rc("rx info", emff_pkg::OFF_RX_INFO, 32'h005DD);
        wr(emff_pkg::OFF_RX_CTL, 32'h1);
        e[19] = ~e[19];
        phy.send(e);
        repeat (4) @(posedge mclk);
        rc("status", emff_pkg::OFF_STATUS, 32'h2);
        rc("rx level", emff_pkg::OFF_RX_LEVEL, 32'h28);
        wr(emff_pkg::OFF_STATUS, 32'h2);
        $display("receive test done");
        e.delete();
        for (int i = 0; i < 2100; i++) begin
            e.push_back(8'(i));
        end
        phy.send(e);
        repeat (4) @(posedge mclk);
        rc("overrun", emff_pkg::OFF_STATUS, 32'h8);
        rc("rx level", emff_pkg::OFF_RX_LEVEL, 32'h28);
        $display("overrun test done");
        // A long frame that still fits must be kept with no error raised.
        wr(emff_pkg::OFF_STATUS, 32'h8);
        wr(emff_pkg::OFF_RX_CTL, 32'h3);
        e.delete();
        for (int i = 0; i < 1600; i++) begin
            e.push_back(8'(i));
        end
        add_fcs(e);
        phy.send(e);
        repeat (4) @(posedge mclk);
        rc("long status", emff_pkg::OFF_STATUS, 32'h2);
        rc("long level", emff_pkg::OFF_RX_LEVEL, 32'h66C);
        $display("long frame test done");
        tally_and_finish();
    end
endmodule
